// [hw/sgp_image.v]
// Purpose: process image of a one-channel strain-gauge readout
// Assumes: command byte held by bus coupler logic on core_clk
// Notes:   weight is two's complement; filter lies outside
//
// Functional notes
// - Weight word, bit 31 sign, two's complement
// - Status byte bit map as documented
// - Steady and calibration bits only internal
// - Freeze blocks samples into filter
// - Freeze status follows freeze command
// - Steady after tolerance held past settle time
// - Leaving window: new reference, restart, clear
// - Calibration measures two references, bit set
// - Calibration repeats at parametrized interval
// - Tare commands acknowledged while bit held
// - Adjustment commands acknowledged while bit held
// - Zero/reference commands acknowledged while held
// - Every command bit except unused bit 5 has status acknowledge
// - Set tare captures value, delete zeroes
// - Failed adjustment command sets error bit
`timescale 1ns/1ps
`include "sgp_regs.vh"

module sgp_image #(
  parameter W = 32
) (
  input  wire         core_clk,
  input  wire         srst,
  input  wire [7:0]   command_byte,
  input  wire         adc_valid,
  input  wire [W-1:0] adc_data,
  input  wire         filt_out_valid,
  input  wire [W-1:0] filt_out_data,
  input  wire [31:0]  settle_time,
  input  wire [W-1:0] settle_tolerance,
  input  wire [31:0]  calibration_interval,
  output reg  [W-1:0] weight_value_word_ff,
  output reg  [7:0]   status_byte_ff,
  output reg          filt_in_valid_ff,
  output reg  [W-1:0] filt_in_data_ff,
  output reg  [1:0]   cal_ref_sel_ff,
  output reg  [W-1:0] cal_span_ff
);

  reg  [7:0]   cmd_q_ff;
  reg  [2:0]   cal_st_ff;
  reg  [31:0]  cal_cnt_ff;
  reg          cal_boot_ff;
  reg  [W-1:0] cal_lo_ff;
  reg  [W-1:0] cal_ofs_ff;
  reg  [W-1:0] filt_last_ff;
  reg  [W-1:0] tare_ff;
  reg  [W-1:0] zero_ofs_ff;
  reg  [W-1:0] ref_raw_ff;
  reg          zero_set_ff;
  reg          ref_set_ff;
  reg  [W-1:0] adj_zero_ff;
  reg  [W-1:0] adj_span_ff;
  reg          adj_valid_ff;
  reg          tare_ack_ff;
  reg          adj_ack_ff;
  reg          adj_err_ff;
  reg          zr_ack_ff;
  reg          net_valid_ff;
  wire [7:0]   rise;
  wire         cal_idle;
  wire         cal_due;
  wire         freeze_cmd;
  wire         adj_fail;
  wire [W-1:0] net_weight;
  wire         steady;
  reg  [W-1:0] nxt_weight;

  function [W-1:0] sgp_net;
    input [W-1:0] raw;
    input [W-1:0] ofs;
    input [W-1:0] tare;
    begin
      sgp_net = raw - ofs - tare;
    end
  endfunction

  assign rise       = command_byte & ~cmd_q_ff;
  assign freeze_cmd = command_byte[`SGP_CMD_FREEZE];
  assign cal_idle   = (cal_st_ff == `SGP_CAL_IDLE);
  assign cal_due    = cal_boot_ff ||
                      ((calibration_interval != `SGP_RST_WORD) && (cal_cnt_ff >= calibration_interval));
  // store needs both points, distinct; delete needs data
  assign adj_fail   = (rise[`SGP_CMD_ADJ_STORE] &&
                       !(zero_set_ff && ref_set_ff && (ref_raw_ff != zero_ofs_ff))) ||
                      (rise[`SGP_CMD_ADJ_DELETE] && !adj_valid_ff);
  assign net_weight = sgp_net(filt_last_ff, zero_ofs_ff, tare_ff);

  always @* begin
    // two's complement, bit 31 carries sign
    nxt_weight = net_weight;
  end

  always @(posedge core_clk) begin
    if (srst)
      cmd_q_ff <= `SGP_RST_BYTE;
    else
      cmd_q_ff <= command_byte;
  end

  always @(posedge core_clk) begin
    if (srst) begin
      cal_st_ff      <= `SGP_CAL_IDLE;
      cal_cnt_ff     <= `SGP_RST_WORD;
      cal_boot_ff    <= 1'b1;
      cal_lo_ff      <= {W{1'b0}};
      cal_ofs_ff     <= {W{1'b0}};
      cal_span_ff    <= {W{1'b0}};
      cal_ref_sel_ff <= `SGP_RST_SEL;
    end else begin
      case (cal_st_ff)
        `SGP_CAL_IDLE: begin
          if (cal_due) begin
            cal_st_ff      <= `SGP_CAL_LO;
            cal_ref_sel_ff <= `SGP_SEL_LO_REF;
            cal_boot_ff    <= 1'b0;
            cal_cnt_ff     <= `SGP_RST_WORD;
          end else begin
            cal_cnt_ff <= cal_cnt_ff + `SGP_ONE;
          end
        end
        `SGP_CAL_LO: begin
          if (adc_valid) begin
            cal_lo_ff      <= adc_data;
            cal_st_ff      <= `SGP_CAL_HI;
            cal_ref_sel_ff <= `SGP_SEL_HI_REF;
          end
        end
        `SGP_CAL_HI: begin
          if (adc_valid) begin
            cal_ofs_ff     <= cal_lo_ff;
            cal_span_ff    <= adc_data - cal_lo_ff;
            cal_st_ff      <= `SGP_CAL_IDLE;
            cal_ref_sel_ff <= `SGP_RST_SEL;
          end
        end
        default: begin
          cal_st_ff      <= `SGP_CAL_IDLE;
          cal_ref_sel_ff <= `SGP_RST_SEL;
        end
      endcase
    end
  end

  // Reference samples never reach the filter
  always @(posedge core_clk) begin
    if (srst) begin
      filt_in_valid_ff <= 1'b0;
      filt_in_data_ff  <= {W{1'b0}};
    end else begin
      filt_in_valid_ff <= adc_valid && !freeze_cmd && cal_idle;
      filt_in_data_ff  <= adc_data - cal_ofs_ff;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      filt_last_ff <= {W{1'b0}};
      net_valid_ff <= 1'b0;
    end else begin
      net_valid_ff <= filt_out_valid;
      if (filt_out_valid)
        filt_last_ff <= filt_out_data;
    end
  end

  // Tare and user adjustment data
  always @(posedge core_clk) begin
    if (srst) begin
      tare_ff      <= {W{1'b0}};
      zero_ofs_ff  <= {W{1'b0}};
      ref_raw_ff   <= {W{1'b0}};
      zero_set_ff  <= 1'b0;
      ref_set_ff   <= 1'b0;
      adj_zero_ff  <= {W{1'b0}};
      adj_span_ff  <= {W{1'b0}};
      adj_valid_ff <= 1'b0;
    end else begin
      if (rise[`SGP_CMD_TARE_DEL])
        tare_ff <= {W{1'b0}};
      else if (rise[`SGP_CMD_TARE_SET])
        tare_ff <= filt_last_ff - zero_ofs_ff;
      if (rise[`SGP_CMD_ZERO_PT]) begin
        zero_ofs_ff <= filt_last_ff;
        zero_set_ff <= 1'b1;
      end
      if (rise[`SGP_CMD_REF_PT]) begin
        ref_raw_ff <= filt_last_ff;
        ref_set_ff <= 1'b1;
      end
      if (rise[`SGP_CMD_ADJ_DELETE] && adj_valid_ff) begin
        adj_valid_ff <= 1'b0;
        adj_zero_ff  <= {W{1'b0}};
        adj_span_ff  <= {W{1'b0}};
        zero_ofs_ff  <= {W{1'b0}};
        zero_set_ff  <= 1'b0;
        ref_set_ff   <= 1'b0;
      end else if (rise[`SGP_CMD_ADJ_STORE] && !adj_fail) begin
        adj_valid_ff <= 1'b1;
        adj_zero_ff  <= zero_ofs_ff;
        adj_span_ff  <= ref_raw_ff - zero_ofs_ff;
      end
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      tare_ack_ff <= 1'b0;
      adj_ack_ff  <= 1'b0;
      adj_err_ff  <= 1'b0;
      zr_ack_ff   <= 1'b0;
    end else begin
      tare_ack_ff <= (tare_ack_ff || rise[`SGP_CMD_TARE_SET] || rise[`SGP_CMD_TARE_DEL]) &&
                     (command_byte[`SGP_CMD_TARE_SET] || command_byte[`SGP_CMD_TARE_DEL]);
      adj_ack_ff  <= (adj_ack_ff || rise[`SGP_CMD_ADJ_STORE] || rise[`SGP_CMD_ADJ_DELETE]) &&
                     (command_byte[`SGP_CMD_ADJ_STORE] || command_byte[`SGP_CMD_ADJ_DELETE]);
      adj_err_ff  <= adj_fail ||
                     (adj_err_ff && (command_byte[`SGP_CMD_ADJ_STORE] || command_byte[`SGP_CMD_ADJ_DELETE]));
      zr_ack_ff   <= (zr_ack_ff || rise[`SGP_CMD_ZERO_PT] || rise[`SGP_CMD_REF_PT]) &&
                     (command_byte[`SGP_CMD_ZERO_PT] || command_byte[`SGP_CMD_REF_PT]);
    end
  end

  sgp_steady #(
    .W (W)
  ) u_steady (
    .core_clk         (core_clk),
    .srst             (srst),
    .val_valid        (net_valid_ff),
    .val_data         (net_weight),
    .settle_time      (settle_time),
    .settle_tolerance (settle_tolerance),
    .steady_ff        (steady)
  );

  always @(posedge core_clk) begin
    if (srst) begin
      status_byte_ff       <= `SGP_RST_BYTE;
      weight_value_word_ff <= {W{1'b0}};
    end else begin
      weight_value_word_ff <= nxt_weight;
      status_byte_ff[`SGP_ST_FREEZE]   <= freeze_cmd;
      status_byte_ff[`SGP_ST_STEADY]   <= steady;
      status_byte_ff[`SGP_ST_CAL]      <= !cal_idle;
      status_byte_ff[`SGP_ST_TARE_CHG] <= tare_ack_ff;
      status_byte_ff[`SGP_ST_ADJ_ERR]  <= adj_err_ff;
      status_byte_ff[`SGP_ST_ADJ_CHG]  <= adj_ack_ff;
      status_byte_ff[`SGP_ST_RSVD]     <= 1'b0;
      status_byte_ff[`SGP_ST_ZERO_REF] <= zr_ack_ff;
    end
  end

endmodule // sgp_image

// [hw/sgp_regs.vh]
// Purpose: constants of the strain-gauge process image
// Assumes: one clock, synchronous reset
// Notes:   bit positions inside command and status bytes
`ifndef SGP_REGS_VH
`define SGP_REGS_VH

// Process image byte offsets
`define SGP_OFS_WEIGHT      4'h0
`define SGP_OFS_COMMAND     4'h0
`define SGP_OFS_STATUS      4'h3

// Command byte bits
`define SGP_CMD_FREEZE      0
`define SGP_CMD_ADJ_STORE   1
`define SGP_CMD_ADJ_DELETE  2
`define SGP_CMD_TARE_SET    3
`define SGP_CMD_TARE_DEL    4
`define SGP_CMD_ZERO_PT     6
`define SGP_CMD_REF_PT      7

// Status byte bits
`define SGP_ST_FREEZE       0
`define SGP_ST_STEADY       1
`define SGP_ST_CAL          2
`define SGP_ST_TARE_CHG     3
`define SGP_ST_ADJ_ERR      4
`define SGP_ST_ADJ_CHG      5
`define SGP_ST_RSVD         6
`define SGP_ST_ZERO_REF     7

// Reset values
`define SGP_RST_BYTE        8'h00
`define SGP_RST_WORD        32'h0000_0000
`define SGP_RST_SEL         2'h0

// Internal reference selects
`define SGP_SEL_LO_REF      2'h1
`define SGP_SEL_HI_REF      2'h2

// Calibration states, one-hot
`define SGP_CAL_IDLE        3'h1
`define SGP_CAL_LO          3'h2
`define SGP_CAL_HI          3'h4

// Counter step
`define SGP_ONE             32'h0000_0001
// Saturation ceiling of the settle counter
`define SGP_CNT_MAX         32'hffff_ffff

`endif

// [hw/sgp_steady.v]
// Purpose: steady-state detector on the weight value
// Assumes: val_valid pulses once per new value
// Notes:   settle time counted in core_clk cycles
`timescale 1ns/1ps
`include "sgp_regs.vh"

module sgp_steady #(
  parameter W = 32
) (
  input  wire         core_clk,
  input  wire         srst,
  input  wire         val_valid,
  input  wire [W-1:0] val_data,
  input  wire [31:0]  settle_time,
  input  wire [W-1:0] settle_tolerance,
  output reg          steady_ff
);

  reg  [W-1:0] ref_ff;
  reg  [31:0]  cnt_ff;
  wire [W-1:0] diff;
  wire [W-1:0] mag;
  wire         outside;

  assign diff    = val_data - ref_ff;
  assign mag     = diff[W-1] ? (~diff + {{(W-1){1'b0}}, 1'b1}) : diff;
  assign outside = val_valid && (mag > settle_tolerance);

  always @(posedge core_clk) begin
    if (srst) begin
      ref_ff    <= {W{1'b0}};
      cnt_ff    <= `SGP_RST_WORD;
      steady_ff <= 1'b0;
    end else if (outside) begin
      ref_ff    <= val_data;
      cnt_ff    <= `SGP_RST_WORD;
      steady_ff <= 1'b0;
    end else begin
      // Saturate so a long rest never wraps back
      if (cnt_ff != `SGP_CNT_MAX)
        cnt_ff <= cnt_ff + `SGP_ONE;
      steady_ff <= (cnt_ff > settle_time);
    end
  end

endmodule // sgp_steady

// [dv/sgp_props.sv]
// Purpose: port checks of the strain-gauge process image
// Assumes: acks settle within two edges of the command
// Notes:   three-sample windows absorb the ack pipeline
`timescale 1ns/1ps
module sgp_props #(
  parameter W = 32
) (
  input wire         core_clk,
  input wire         srst,
  input wire [7:0]   command_byte,
  input wire         adc_valid,
  input wire         filt_out_valid,
  input wire [7:0]   status_byte_ff,
  input wire         filt_in_valid_ff,
  input wire [1:0]   cal_ref_sel_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire [7:0] c = command_byte;
  wire [7:0] s = status_byte_ff;
  a_freeze_on: assert property (c[0] [*3] |-> s[0]) else $error("freeze flag missing");
  a_freeze_off: assert property (!c[0] [*3] |-> !s[0]) else $error("freeze flag stuck");
  a_tare_hold: assert property ((c[3] | c[4]) [*3] |-> s[3]) else $error("tare ack missing");
  a_tare_drop: assert property (!(c[3] | c[4]) [*3] |-> !s[3]) else $error("tare ack stuck");
  a_adj_hold: assert property ((c[1] | c[2]) [*3] |-> s[5]) else $error("adj ack missing");
  a_adj_drop: assert property (!(c[1] | c[2]) [*3] |-> !s[5] && !s[4]) else $error("adj flag stuck");
  a_zref_hold: assert property ((c[6] | c[7]) [*3] |-> s[7]) else $error("zero ack missing");
  a_zref_drop: assert property (!(c[6] | c[7]) [*3] |-> !s[7]) else $error("zero ack stuck");
  a_rsvd_low: assert property (!s[6]) else $error("reserved bit set");
  a_cal_flag: assert property (s[2] == ($past(cal_ref_sel_ff) != 2'h0)) else $error("cal flag wrong");
  a_feed_freeze: assert property (filt_in_valid_ff |-> $past(adc_valid) && !$past(c[0])) else $error("bad feed");
  a_steady_keep: assert property ((s[1] && !filt_out_valid) [*4] |=> s[1]) else $error("steady lost");
  cover property ($rose(s[1]));
  cover property ($rose(s[2]));
  cover property ($rose(s[4]));
endmodule // sgp_props

bind sgp_image sgp_props #(.W(W)) sgp_props_i (.core_clk(core_clk), .srst(srst), .command_byte(command_byte),
  .adc_valid(adc_valid), .filt_out_valid(filt_out_valid), .status_byte_ff(status_byte_ff),
  .filt_in_valid_ff(filt_in_valid_ff), .cal_ref_sel_ff(cal_ref_sel_ff));

// [dv/sgp_coupler.sv]
// Purpose: coupler side that owns the command byte
// Assumes: bench asks for a command mask
// Notes:   command held as a level, changed off the sampling edge
`timescale 1ns/1ps
module sgp_coupler (
  input wire       core_clk,
  input wire [7:0] want,
  output reg [7:0] command_byte
);
  initial command_byte = 8'h00;
  always @(negedge core_clk) begin
    command_byte <= want & 8'hdf;
  end
endmodule // sgp_coupler

// [dv/sgp_image_tb.sv]
// Purpose: self-checking bench of the process image
// Assumes: settle 20, tolerance 16, interval 200 cycles
// Notes:   weight checks go through a queue of noted values
`timescale 1ns/1ps
module sgp_image_tb;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg  [7:0]  want = 8'h00;
  reg         adc_valid = 1'b0;
  reg  [31:0] adc_data = 32'h0;
  reg         filt_out_valid = 1'b0;
  reg  [31:0] fod = 32'h0;
  reg  [31:0] rnd = 32'h9bfa;
  reg  [31:0] last = 32'h0;
  reg  [31:0] tare = 32'h0;
  reg  [31:0] zero = 32'h0;
  reg  [2:0]  pipe = 3'h0;
  reg  [31:0] exp_q [$];
  integer     error_cnt = 0;
  integer     tests_run = 0;
  integer     cyc = 0;
  integer     i;
  wire [7:0]  command_byte;
  wire [7:0]  st;
  wire [31:0] wt;
  wire        fiv;
  wire [1:0]  sel;
  wire [31:0] fid;
  wire [31:0] span;
  // Internal reference levels seen while calibration selects them
  localparam [31:0] ref_lo = 32'h0000_0100;
  localparam [31:0] ref_hi = 32'h0000_0900;
  always #5 core_clk = ~core_clk;
  sgp_coupler sgp_coupler_i (.core_clk(core_clk), .want(want), .command_byte(command_byte));
  sgp_image sgp_image_i (.core_clk(core_clk), .srst(srst), .command_byte(command_byte), .adc_valid(adc_valid),
    .adc_data(adc_data), .filt_out_valid(filt_out_valid), .filt_out_data(fod), .settle_time(32'h14),
    .settle_tolerance(32'h10), .calibration_interval(32'hc8), .weight_value_word_ff(wt), .status_byte_ff(st),
    .filt_in_valid_ff(fiv), .filt_in_data_ff(fid), .cal_ref_sel_ff(sel), .cal_span_ff(span));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task feed(input [31:0] v);
    begin
      @(negedge core_clk);
      filt_out_valid = 1'b1;
      fod = v;
      last = v;
      exp_q.push_back(v - zero - tare);
      @(negedge core_clk);
      filt_out_valid = 1'b0;
      repeat (3) @(negedge core_clk);
    end
  endtask
  task feed_rnd;
    begin
      rnd = xs(rnd);
      feed({{16{rnd[15]}}, rnd[15:0]});
    end
  endtask
  task cmd(input [7:0] m);
    begin
      @(negedge core_clk);
      // Non-blocking so the coupler picks it up one edge later, race free
      want <= m;
      repeat (4) @(negedge core_clk);
    end
  endtask
  // Sample source kept running so calibration always finds samples
  always @(negedge core_clk) begin
    adc_valid <= (cyc[1:0] == 2'h0);
    if (sel == 2'h1) adc_data <= ref_lo;
    else if (sel == 2'h2) adc_data <= ref_hi;
    else adc_data <= cyc;
  end
  // Filter feed: old input values still stand at this edge
  always @(negedge core_clk) begin
    if (adc_valid && command_byte[0]) chk(fiv, 1'b0);
    if (fiv) chk(fid, adc_data - ref_lo);
  end
  always @(posedge core_clk) pipe <= {pipe[1:0], filt_out_valid};
  always @(negedge core_clk) begin
    if (pipe[2]) chk(wt, exp_q.pop_front());
  end
  // Hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  initial begin
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(st[2], 1'b1);
    repeat (30) @(negedge core_clk);
    chk(st[2], 1'b0);
    chk(span, ref_hi - ref_lo);
    cmd(8'h01);
    chk(st[0], 1'b1);
    cmd(8'h00);
    chk(st[0], 1'b0);
    for (i = 0; i < 6; i = i + 1) feed_rnd;
    cmd(8'h08);
    tare = last - zero;
    chk(st[3], 1'b1);
    cmd(8'h00);
    chk(st[3], 1'b0);
    feed_rnd;
    cmd(8'h10);
    tare = 32'h0;
    chk(st[3], 1'b1);
    cmd(8'h00);
    feed_rnd;
    cmd(8'h40);
    zero = last;
    chk(st[7], 1'b1);
    cmd(8'h00);
    feed_rnd;
    cmd(8'h02);
    chk({st[5], st[4]}, 2'h3);
    cmd(8'h00);
    chk({st[5], st[4]}, 2'h0);
    feed(last + 32'h40);
    cmd(8'h80);
    chk(st[7], 1'b1);
    cmd(8'h00);
    cmd(8'h02);
    chk({st[5], st[4]}, 2'h2);
    cmd(8'h00);
    cmd(8'h04);
    zero = 32'h0;
    chk({st[5], st[4]}, 2'h2);
    cmd(8'h00);
    cmd(8'h04);
    chk({st[5], st[4]}, 2'h3);
    cmd(8'h00);
    for (i = 0; i < 8; i = i + 1) feed(32'h500);
    chk(st[1], 1'b1);
    feed(32'h600);
    chk(st[1], 1'b0);
    repeat (10) @(negedge core_clk);
    chk(st[1], 1'b0);
    repeat (20) @(negedge core_clk);
    chk(st[1], 1'b1);
    for (i = 0; i < 400 && st[2] !== 1'b1; i = i + 1) @(negedge core_clk);
    chk(st[2], 1'b1);
    final_report;
  end
endmodule // sgp_image_tb
